// file: inc/arf_cfg.svh
// Constants for the converter result store and channel decode.
// Assumes inclusion by bare name from package and rtl files.
`ifndef ARF_CFG_SVH
`define ARF_CFG_SVH

`define ARF_ENTRIES       64
`define ARF_IDX_W         6
`define ARF_RES_W         10
`define ARF_DATA_W        16
`define ARF_ADDR_W        32
`define ARF_BYTE_W        8
`define ARF_RJU_BASE      32'h00ca0280
`define ARF_LJS_BASE      32'h00ca0300
`define ARF_LJU_BASE      32'h00ca0380
`define ARF_VIEW_BYTES    32'h00000080
`define ARF_HALF_SCALE    10'h200
`define ARF_LJ_SHIFT      6
`define ARF_CHANNEL_FIELD_EOQ      6'h3f
`define ARF_CHANNEL_FIELD_VRL      6'h3c
`define ARF_CHANNEL_FIELD_VRH      6'h3d
`define ARF_CHANNEL_FIELD_VMID     6'h3e
`define ARF_CHANNEL_FIELD_MA_LOW   6'h34
`define ARF_CHANNEL_FIELD_MA_HIGH  6'h35
`define ARF_CHANNEL_FIELD_TRIG1    6'h37
`define ARF_CHANNEL_FIELD_TRIG2    6'h38
`define ARF_MUX_MASK      6'h39
`define ARF_MUX_A_PAT     6'h00
`define ARF_MUX_B_PAT     6'h01
`define ARF_MUX_C_PAT     6'h10
`define ARF_MUX_D_PAT     6'h11
`define ARF_DIRECT_MASK   6'h3c
`define ARF_DIRECT_PAT    6'h00

`endif

// file: inc/arf_pkg.sv
// Types for the converter result store and channel decode.
// Assumes arf_cfg.svh is on the include path.
`include "arf_cfg.svh"

package arf_pkg;
  typedef enum logic [1:0] {
    ARF_VIEW_RJU  = 2'b00,
    ARF_VIEW_LJS  = 2'b01,
    ARF_VIEW_LJU  = 2'b10,
    ARF_VIEW_NONE = 2'b11
  } arf_view_e;

  typedef enum logic [2:0] {
    ARF_SRC_PIN  = 3'b000,
    ARF_SRC_EXT  = 3'b001,
    ARF_SRC_REF  = 3'b010,
    ARF_SRC_EOQ  = 3'b011,
    ARF_SRC_RSVD = 3'b100
  } arf_src_e;

  typedef enum logic [1:0] {
    ARF_CV_IDLE = 2'b00,
    ARF_CV_BUSY = 2'b01
  } arf_cv_e;

  typedef logic [`ARF_RES_W-1:0] arf_res_t;
  typedef logic [`ARF_IDX_W-1:0] arf_idx_t;
endpackage

// file: rtl/arf_channel_field_decode.sv
// Channel-field decode: classifies a command word's channel code.
// Assumes a static channel code; purely combinational.
`timescale 1ns/1ps
`include "arf_cfg.svh"

module arf_channel_field_decode (
  // Channel code and mode
  input  wire logic [5:0] channel_field_in,
  input  wire logic       ext_mux_en_in,
  // Classification
  output arf_pkg::arf_src_e src_out,
  output logic [1:0]        mux_input_sel_out,
  output logic [1:0]        mux_addr_out
);

  function automatic logic match(input logic [5:0] c, input logic [5:0] m, input logic [5:0] p);
    match = ((c & m) == p);
  endfunction

  always_comb begin
    src_out           = arf_pkg::ARF_SRC_RSVD;
    mux_input_sel_out = 2'b00;
    mux_addr_out      = channel_field_in[2:1];
    if (channel_field_in == `ARF_CHANNEL_FIELD_EOQ) begin
      src_out = arf_pkg::ARF_SRC_EOQ;
    end else if (channel_field_in == `ARF_CHANNEL_FIELD_VRL || channel_field_in == `ARF_CHANNEL_FIELD_VRH ||
                 channel_field_in == `ARF_CHANNEL_FIELD_VMID) begin
      src_out = arf_pkg::ARF_SRC_REF;
    end else if (channel_field_in == `ARF_CHANNEL_FIELD_TRIG1 || channel_field_in == `ARF_CHANNEL_FIELD_TRIG2) begin
      src_out = arf_pkg::ARF_SRC_PIN;
    end else if (ext_mux_en_in) begin
      // Four multiplexed inputs, XX picks the external input
      if (match(channel_field_in, `ARF_MUX_MASK, `ARF_MUX_A_PAT)) begin
        src_out           = arf_pkg::ARF_SRC_EXT;
        mux_input_sel_out = 2'd0;
      end else if (match(channel_field_in, `ARF_MUX_MASK, `ARF_MUX_B_PAT)) begin
        src_out           = arf_pkg::ARF_SRC_EXT;
        mux_input_sel_out = 2'd1;
      end else if (match(channel_field_in, `ARF_MUX_MASK, `ARF_MUX_C_PAT)) begin
        src_out           = arf_pkg::ARF_SRC_EXT;
        mux_input_sel_out = 2'd2;
      end else if (match(channel_field_in, `ARF_MUX_MASK, `ARF_MUX_D_PAT)) begin
        src_out           = arf_pkg::ARF_SRC_EXT;
        mux_input_sel_out = 2'd3;
      end else begin
        src_out = arf_pkg::ARF_SRC_RSVD;
      end
    end else if (match(channel_field_in, `ARF_DIRECT_MASK, `ARF_DIRECT_PAT) ||
                 channel_field_in == `ARF_CHANNEL_FIELD_MA_LOW || channel_field_in == `ARF_CHANNEL_FIELD_MA_HIGH) begin
      src_out = arf_pkg::ARF_SRC_PIN;
    end else begin
      src_out = arf_pkg::ARF_SRC_RSVD;
    end
  end

endmodule

// file: rtl/arf_view_fmt.sv
// Formats one stored result into the three read views.
// Assumes a 10-bit result; purely combinational.
`timescale 1ns/1ps
`include "arf_cfg.svh"

module arf_view_fmt (
  // Stored value and view
  input  wire logic [`ARF_RES_W-1:0] result_in,
  input  arf_pkg::arf_view_e         view_in,
  // Formatted half-word
  output logic [`ARF_DATA_W-1:0]     data_out
);

  logic sign_bit;

  always_comb begin
    sign_bit = (result_in < `ARF_HALF_SCALE);
    case (view_in)
      arf_pkg::ARF_VIEW_RJU: data_out = {6'h00, result_in};
      arf_pkg::ARF_VIEW_LJS: data_out = {sign_bit, result_in[8:0], 6'h00};
      arf_pkg::ARF_VIEW_LJU: data_out = {result_in, 6'h00};
      default:               data_out = 16'h0000;
    endcase
  end

endmodule

// file: rtl/arf_result_store.sv
// Result table, three aliased read views and external-mux addressing.
// Assumes a synchronous half-word/byte bus slave with one-cycle read data
// and a queue engine that reports completed conversions by index.
`timescale 1ns/1ps
`include "arf_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////////////

module arf_result_store (
  // Clock and reset
  input  wire logic                    sys_clk_in,
  input  wire logic                    rst_in,
  // Register bus
  input  wire logic                    bus_sel_in,
  input  wire logic                    bus_wr_in,
  input  wire logic [`ARF_ADDR_W-1:0]  bus_addr_in,
  input  wire logic [1:0]              bus_byte_en_in,
  input  wire logic [`ARF_DATA_W-1:0]  bus_wdata_in,
  output logic [`ARF_DATA_W-1:0]       bus_rdata_out,
  output logic                         bus_ack_out,
  output logic                         bus_err_out,
  // Module mode
  input  wire logic                    stop_mode_in,
  input  wire logic                    ext_mux_en_in,
  // Conversion engine
  input  wire logic                    conv_start_in,
  input  wire logic [5:0]              channel_field_in,
  input  wire logic                    conv_done_in,
  input  wire logic [`ARF_IDX_W-1:0]   conv_idx_in,
  input  wire logic [`ARF_RES_W-1:0]   conv_result_in,
  output arf_pkg::arf_src_e            conv_src_out,
  output logic [1:0]                   mux_input_sel_out,
  // Port A pins 0 and 1
  input  wire logic [1:0]              port_a_direction_in,
  input  wire logic [1:0]              port_a_data_in,
  output logic                         mux_addr_low_out,
  output logic                         mux_addr_high_out,
  output logic [1:0]                   port_a_oe_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  function automatic logic in_view(input logic [`ARF_ADDR_W-1:0] a, input logic [`ARF_ADDR_W-1:0] b);
    in_view = (a >= b) && (a < b + `ARF_VIEW_BYTES);
  endfunction

  function automatic arf_pkg::arf_view_e view_of(input logic [`ARF_ADDR_W-1:0] a);
    if (in_view(a, `ARF_RJU_BASE)) begin
      view_of = arf_pkg::ARF_VIEW_RJU;
    end else if (in_view(a, `ARF_LJS_BASE)) begin
      view_of = arf_pkg::ARF_VIEW_LJS;
    end else if (in_view(a, `ARF_LJU_BASE)) begin
      view_of = arf_pkg::ARF_VIEW_LJU;
    end else begin
      view_of = arf_pkg::ARF_VIEW_NONE;
    end
  endfunction

  // Lanes left disabled keep the current view image
  function automatic logic [`ARF_DATA_W-1:0] merge_lanes(input logic [`ARF_DATA_W-1:0] old_word,
                                                         input logic [`ARF_DATA_W-1:0] new_word,
                                                         input logic [1:0]             lanes);
    merge_lanes = old_word;
    if (lanes[0]) begin
      merge_lanes[`ARF_BYTE_W-1:0] = new_word[`ARF_BYTE_W-1:0];
    end
    if (lanes[1]) begin
      merge_lanes[`ARF_DATA_W-1:`ARF_BYTE_W] = new_word[`ARF_DATA_W-1:`ARF_BYTE_W];
    end
  endfunction

  // Stored value recovered from a view image; zero bits drop out
  function automatic arf_pkg::arf_res_t unview(input logic [`ARF_DATA_W-1:0] w,
                                               input arf_pkg::arf_view_e     v);
    case (v)
      arf_pkg::ARF_VIEW_LJS: unview = {~w[`ARF_DATA_W-1], w[`ARF_DATA_W-2:`ARF_LJ_SHIFT]};
      arf_pkg::ARF_VIEW_LJU: unview = w[`ARF_DATA_W-1:`ARF_LJ_SHIFT];
      default:               unview = w[`ARF_RES_W-1:0];
    endcase
  endfunction

  arf_pkg::arf_view_e             acc_view;
  arf_pkg::arf_idx_t              acc_idx;
  logic                           acc_rd;
  logic                           acc_wr;
  logic [`ARF_DATA_W-1:0]         fmt_data;
  logic [`ARF_DATA_W-1:0]         sw_word;
  logic [`ARF_RES_W-1:0]          sw_result;

  always_comb begin
    acc_view = view_of(bus_addr_in);
    acc_idx  = bus_addr_in[`ARF_IDX_W:1];
    acc_rd   = bus_sel_in && !bus_wr_in;
    acc_wr   = bus_sel_in && bus_wr_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result table

  arf_pkg::arf_res_t result_reg [`ARF_ENTRIES];
  arf_pkg::arf_res_t result_next [`ARF_ENTRIES];
  logic              sw_wr;

  arf_view_fmt u_fmt (
    .result_in (result_reg[acc_idx]),
    .view_in   (acc_view),
    .data_out  (fmt_data)
  );

  always_comb begin
    // Merge written bytes over current view image
    sw_word   = merge_lanes(fmt_data, bus_wdata_in, bus_byte_en_in);
    sw_result = unview(sw_word, acc_view);
    sw_wr     = acc_wr && !stop_mode_in &&
            (acc_view != arf_pkg::ARF_VIEW_NONE) && (bus_byte_en_in != 2'b00);
    for (int i = 0; i < `ARF_ENTRIES; i++) begin
      result_next[i] = result_reg[i];
    end
    if (sw_wr) begin
      result_next[acc_idx] = sw_result;
    end
    // Conversion update never waits on bus activity; it wins a same-entry clash
    if (conv_done_in) begin
      result_next[conv_idx_in] = conv_result_in;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    for (int i = 0; i < `ARF_ENTRIES; i++) begin
      result_reg[i] <= result_next[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus answer

  logic [`ARF_DATA_W-1:0] rdata_reg;
  logic [`ARF_DATA_W-1:0] rdata_next;
  logic                   ack_reg;
  logic                   ack_next;
  logic                   err_reg;
  logic                   err_next;

  always_comb begin
    rdata_next = 16'h0000;
    ack_next   = 1'b0;
    err_next   = 1'b0;
    if (bus_sel_in) begin
      ack_next = 1'b1;
      // Only unmapped addresses answer with an error
      err_next = (acc_view == arf_pkg::ARF_VIEW_NONE);
    end
    if (acc_rd) begin
      rdata_next = fmt_data;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      rdata_reg <= 16'h0000;
      ack_reg   <= 1'b0;
      err_reg   <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      ack_reg   <= ack_next;
      err_reg   <= err_next;
    end
  end

  assign bus_rdata_out = rdata_reg;
  assign bus_ack_out   = ack_reg;
  assign bus_err_out   = err_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Channel decode and external mux address

  arf_pkg::arf_cv_e  cv_reg;
  arf_pkg::arf_cv_e  cv_next;
  logic [5:0]        channel_field_reg;
  logic [5:0]        channel_field_next;
  logic [1:0]        ma_reg;
  logic [1:0]        ma_next;
  logic [1:0]        dec_ma;
  arf_pkg::arf_src_e src_reg;
  arf_pkg::arf_src_e src_next;
  arf_pkg::arf_src_e dec_src;
  logic [1:0]        msel_reg;
  logic [1:0]        msel_next;
  logic [1:0]        dec_msel;

  // Decoding the next channel lets the class register line up with channel_field_reg
  arf_channel_field_decode u_dec (
    .channel_field_in  (channel_field_next),
    .ext_mux_en_in     (ext_mux_en_in),
    .src_out           (dec_src),
    .mux_input_sel_out (dec_msel),
    .mux_addr_out      (dec_ma)
  );

  always_comb begin
    cv_next   = cv_reg;
    channel_field_next = channel_field_reg;
    case (cv_reg)
      arf_pkg::ARF_CV_IDLE: begin
        // Latch only a real conversion request outside stop mode
        if (conv_start_in && !stop_mode_in && channel_field_in != `ARF_CHANNEL_FIELD_EOQ) begin
          cv_next   = arf_pkg::ARF_CV_BUSY;
          channel_field_next = channel_field_in;
        end
      end
      arf_pkg::ARF_CV_BUSY: begin
        if (conv_done_in) begin
          cv_next = arf_pkg::ARF_CV_IDLE;
        end
      end
      default: cv_next = arf_pkg::ARF_CV_IDLE;
    endcase
    if (stop_mode_in) begin
      cv_next = arf_pkg::ARF_CV_IDLE;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      cv_reg   <= arf_pkg::ARF_CV_IDLE;
      channel_field_reg <= 6'h00;
    end else begin
      cv_reg   <= cv_next;
      channel_field_reg <= channel_field_next;
    end
  end

  // Class, mux select and address follow the latched channel
  always_comb begin
    src_next  = dec_src;
    msel_next = dec_msel;
    ma_next   = dec_ma;
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      src_reg  <= arf_pkg::ARF_SRC_PIN;
      msel_reg <= 2'b00;
      ma_reg   <= 2'b00;
    end else begin
      src_reg  <= src_next;
      msel_reg <= msel_next;
      ma_reg   <= ma_next;
    end
  end

  assign conv_src_out      = src_reg;
  assign mux_input_sel_out = msel_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Port A pin ownership

  always_comb begin
    if (ext_mux_en_in) begin
      // Pins become outputs whatever their direction bits say
      port_a_oe_out     = 2'b11;
      mux_addr_low_out  = ma_reg[0];
      mux_addr_high_out = ma_reg[1];
    end else begin
      port_a_oe_out     = port_a_direction_in;
      mux_addr_low_out  = port_a_data_in[0];
      mux_addr_high_out = port_a_data_in[1];
    end
  end

endmodule

// file: dv/arf_sva.sv
// Checker for the result store bus and mux pins.
// Assumes a bind onto arf_result_store.
`timescale 1ns/1ps
module arf_sva (
  // Clock, reset, bus
  input wire logic        sys_clk_in,
  input wire logic        rst_in,
  input wire logic        bus_sel_in,
  input wire logic        bus_wr_in,
  input wire logic [31:0] bus_addr_in,
  input wire logic [15:0] bus_rdata_out,
  input wire logic        bus_ack_out,
  input wire logic        bus_err_out,
  // Mux pins
  input wire logic        ext_mux_en_in,
  input wire logic        conv_start_in,
  input wire logic [1:0]  port_a_direction_in,
  input wire logic [1:0]  port_a_data_in,
  input wire logic        mux_addr_low_out,
  input wire logic        mux_addr_high_out,
  input wire logic [1:0]  port_a_oe_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  wire logic map_w = bus_addr_in >= 32'h00ca0280 && bus_addr_in <= 32'h00ca03ff;
  wire logic rju_w = bus_addr_in >= 32'h00ca0280 && bus_addr_in <= 32'h00ca02ff;
  wire logic rd_w  = bus_sel_in && !bus_wr_in;
  wire logic [1:0] ma_w = {mux_addr_high_out, mux_addr_low_out};

  chk_ack_follow: assert property (bus_sel_in |=> bus_ack_out) else $error("ack missing");
  chk_ack_only: assert property (!bus_sel_in |=> !bus_ack_out) else $error("stray ack");
  chk_err_map: assert property (bus_sel_in |=> bus_err_out != $past(map_w)) else $error("bad err");
  chk_rdata_idle: assert property (!bus_ack_out |-> bus_rdata_out == 16'h0) else $error("rdata idle");
  chk_rju_zero: assert property (rd_w && rju_w |=> bus_rdata_out[15:10] == 6'h0) else $error("rju top");
  chk_lj_low: assert property (rd_w && map_w && !rju_w |=> bus_rdata_out[5:0] == 6'h0) else $error("lj low");
  chk_oe_ext: assert property (ext_mux_en_in |-> port_a_oe_out == 2'h3) else $error("oe ext");
  chk_pin_norm: assert property (!ext_mux_en_in |-> port_a_oe_out == port_a_direction_in
    && ma_w == port_a_data_in) else $error("pins normal");
  chk_ma_hold: assert property (ext_mux_en_in && $past(ext_mux_en_in) && !$past(conv_start_in)
    && !$past(rst_in) |-> $stable(ma_w)) else $error("ma moved");

  cover property (rd_w && rju_w);
  cover property (bus_err_out);
  cover property (ext_mux_en_in && conv_start_in);
endmodule

bind arf_result_store arf_sva u_sva (.sys_clk_in, .rst_in, .bus_sel_in, .bus_wr_in, .bus_addr_in,
  .bus_rdata_out, .bus_ack_out, .bus_err_out, .ext_mux_en_in, .conv_start_in, .port_a_direction_in,
  .port_a_data_in, .mux_addr_low_out, .mux_addr_high_out, .port_a_oe_out);

// file: dv/arf_ext_mux.sv
// External four-input mux bank driven by the shared address pins.
// Assumes the pins count only while driven by the device.
`timescale 1ns/1ps
module arf_ext_mux (
  // Address pins
  input wire logic       ma_low_in,
  input wire logic       ma_high_in,
  input wire logic [1:0] oe_in,
  // Input picked on every mux
  output logic [1:0]     pick_out
);
  // Unless both pins are driven, both pins read as the inverse of the data
  assign pick_out = (oe_in == 2'h3) ? {ma_high_in, ma_low_in} : ~{ma_high_in, ma_low_in};
endmodule

// file: dv/testbench.sv
// Self-checking bench for the converter result store.
// Assumes checker and mux model are compiled first.
`timescale 1ns/1ps
module testbench;
  logic              clk = 1'h0, rst = 1'h1, sel = 1'h0, wr = 1'h0, stop = 1'h0, ext = 1'h0, cs = 1'h0, cd = 1'h0;
  logic [31:0]       addr = 32'h0;
  logic [15:0]       wd = 16'h0, rd, lf = 16'hbe7a;
  logic [9:0]        cres = 10'h0, bnd[4] = '{10'h0, 10'h1ff, 10'h200, 10'h3ff};
  logic [5:0]        channel_field = 6'h0, cidx = 6'h0;
  logic [1:0]        be = 2'h0, dir = 2'h0, pdat = 2'h0, msel, oe, pick;
  logic              ack, err, ma_l, ma_h;
  arf_pkg::arf_src_e src;
  int                mdl[64], failures = 0, checks_done = 0;

  always #10 clk = ~clk;

  arf_result_store dut (
    .sys_clk_in(clk), .rst_in(rst), .bus_sel_in(sel), .bus_wr_in(wr), .bus_addr_in(addr),
    .bus_byte_en_in(be), .bus_wdata_in(wd), .bus_rdata_out(rd), .bus_ack_out(ack), .bus_err_out(err),
    .stop_mode_in(stop), .ext_mux_en_in(ext), .conv_start_in(cs), .channel_field_in(channel_field),
    .conv_done_in(cd), .conv_idx_in(cidx), .conv_result_in(cres), .conv_src_out(src),
    .mux_input_sel_out(msel), .port_a_direction_in(dir), .port_a_data_in(pdat),
    .mux_addr_low_out(ma_l), .mux_addr_high_out(ma_h), .port_a_oe_out(oe));
  arf_ext_mux pm (.ma_low_in(ma_l), .ma_high_in(ma_h), .oe_in(oe), .pick_out(pick));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] nxt(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [15:0] fmt(int v, int w);
    logic [9:0] r;
    r = v[9:0];
    if (w == 0) return {6'h0, r};
    if (w == 1) return {~r[9], r[8:0], 6'h0};
    return {r, 6'h0};
  endfunction

  function automatic logic [2:0] src_of(int c);
    if (c >= 60) return arf_pkg::ARF_SRC_REF;
    if (c < 4 || c == 52 || c == 53 || c == 55 || c == 56) return arf_pkg::ARF_SRC_PIN;
    return arf_pkg::ARF_SRC_RSVD;
  endfunction

  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic acc(logic w, int vw, int ix, logic [1:0] b, logic [15:0] d);
    logic [15:0] c;
    @(posedge clk);
    sel <= 1'h1;
    wr <= w;
    addr <= 32'h00ca0280 + vw * 128 + ix * 2;
    be <= b;
    wd <= d;
    @(posedge clk);
    sel <= 1'h0;
    #1;
    chk("ack", 16'h1, ack);
    chk("err", {15'h0, vw < 0 || vw > 2}, err);
    if (vw >= 0 && vw < 3 && !stop) begin
      c = fmt(mdl[ix], vw);
      if (!w) chk("rdata", c, rd);
      if (w) begin
        c[7:0] = b[0] ? d[7:0] : c[7:0];
        c[15:8] = b[1] ? d[15:8] : c[15:8];
        mdl[ix] = vw == 0 ? c[9:0] : vw == 2 ? c[15:6] : {~c[15], c[14:6]};
      end
    end
  endtask

  task automatic conv(int ix, logic [9:0] v);
    @(posedge clk);
    cd <= 1'h1;
    cidx <= ix[5:0];
    cres <= v;
    @(posedge clk);
    cd <= 1'h0;
    mdl[ix] = v;
  endtask

  task automatic start(logic [5:0] c);
    lf = nxt(lf);
    @(posedge clk);
    cs <= 1'h1;
    channel_field <= c;
    dir <= lf[1:0];
    pdat <= lf[3:2];
    @(posedge clk);
    cs <= 1'h0;
    #1;
  endtask

  task automatic give_verdict;
    if (failures == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    for (int i = 0; i < 64; i++) begin
      lf = nxt(lf);
      conv(i, i < 4 ? bnd[i] : lf[9:0]);
    end
    for (int i = 0; i < 64; i++)
      for (int w = 0; w < 3; w++) acc(1'h0, w, i, 2'h3, 16'h0);
    for (int w = 0; w < 3; w++) begin
      lf = nxt(lf);
      acc(1'h1, w, w + 8, 2'h3, lf);
      for (int v = 0; v < 3; v++) acc(1'h0, v, w + 8, 2'h3, 16'h0);
      acc(1'h1, w, w + 16, w[1:0], ~lf);
      acc(1'h0, w, w + 16, 2'h3, 16'h0);
    end
    @(posedge clk);
    stop <= 1'h1;
    acc(1'h1, 0, 5, 2'h3, 16'hffff);
    acc(1'h0, 0, 5, 2'h3, 16'h0);
    @(posedge clk);
    stop <= 1'h0;
    acc(1'h0, 0, 5, 2'h3, 16'h0);
    acc(1'h0, 3, 0, 2'h3, 16'h0);
    acc(1'h1, -1, 63, 2'h3, 16'h1);
    fork
      acc(1'h0, 0, 30, 2'h3, 16'h0);
      conv(31, 10'h2aa);
    join
    acc(1'h0, 0, 31, 2'h3, 16'h0);
    for (int c = 0; c < 63; c++) begin
      start(c[5:0]);
      chk("src", src_of(c), src);
      chk("oe", dir, oe);
      chk("ma", pdat, {ma_h, ma_l});
      conv(c, lf[9:0]);
    end
    start(6'h3f);
    chk("src", arf_pkg::ARF_SRC_REF, src);
    @(posedge clk);
    ext <= 1'h1;
    for (int i = 0; i < 16; i++) begin
      start({1'h0, i[3], 1'h0, i[2:0]});
      chk("pick", i[2:1], pick);
      chk("msel", {i[3], i[0]}, msel);
      chk("src", arf_pkg::ARF_SRC_EXT, src);
      start(6'h3c);
      chk("hold", i[2:1], pick);
      conv(i, lf[9:0]);
      acc(1'h0, 0, i, 2'h3, 16'h0);
    end
    start(6'h34);
    chk("src", arf_pkg::ARF_SRC_RSVD, src);
    chk("pick", 16'h2, pick);
    give_verdict();
  end

  initial begin
    repeat (50000) @(posedge clk);
    failures++;
    give_verdict();
  end
endmodule
